// [hw/csf_pkg.sv]
// Package of constants and carrier types for the CPU status and control flag block
package csf_pkg;

  localparam int unsigned CSF_WORD_W = 24;      // Accumulator, extension, command, buffer width
  localparam int unsigned CSF_ADDR_W = 14;      // Program counter and index width
  localparam int unsigned CSF_NUM_SEL = 12;     // Display selector count
  localparam int unsigned CSF_NUM_IDX = 8;      // Index register count
  localparam int unsigned CSF_NUM_CSW = 6;      // Console sense switches
  localparam int unsigned CSF_NUM_PSW = 8;      // Program sense flip-flops
  localparam int unsigned CSF_NUM_PER = 9;      // Peripheral status lamps
  localparam int unsigned CSF_OP_W = 6;         // Op code field width
  localparam int unsigned CSF_OP_LSB = 18;      // Op code field position in a command word
  localparam logic [CSF_OP_W-1:0] CSF_OP_ILL_LO = 6'h21;  // Octal 41
  localparam logic [CSF_OP_W-1:0] CSF_OP_ILL_HI = 6'h3f;  // Octal 77
  localparam logic [CSF_ADDR_W-1:0] CSF_PC_RESET = 14'h0040;  // Octal 00100
  localparam int unsigned CSF_SIGN_BIT = 23;    // Accumulator sign position
  // Selector indices: A, E, C, B, then index 0..7
  localparam int unsigned CSF_SEL_ACC = 0;
  localparam int unsigned CSF_SEL_EXT = 1;
  localparam int unsigned CSF_SEL_CMD = 2;
  localparam int unsigned CSF_SEL_BUF = 3;
  localparam int unsigned CSF_SEL_IDX0 = 4;
  localparam logic [CSF_NUM_SEL-1:0] CSF_SEL_RESET = 12'h001;  // Accumulator shown after reset
  // Peripheral lamp positions
  localparam int unsigned CSF_PER_MEM_A_PAR = 0;
  localparam int unsigned CSF_PER_MEM_B_PAR = 1;
  localparam int unsigned CSF_PER_MEM_A_BSY = 2;
  localparam int unsigned CSF_PER_MEM_B_BSY = 3;
  localparam int unsigned CSF_PER_DISC_PAR = 4;
  localparam int unsigned CSF_PER_DISC_BSY = 5;
  localparam int unsigned CSF_PER_TAPE_PAR = 6;
  localparam int unsigned CSF_PER_TAPE_BSY = 7;
  localparam int unsigned CSF_PER_AWAIT = 8;

  // Compare result from the arithmetic unit
  typedef struct packed {
    logic greater;
    logic same;
    logic less;
    logic bit_match;
  } csf_cmp_t;

  // Condition lamps
  typedef struct packed {
    logic greater_flag;
    logic same_value_flag;
    logic less_flag;
    logic bit_match_flag;
    logic arith_excess_flag;
    logic sign_flag;
  } csf_cond_t;

  // Control lamps
  typedef struct packed {
    logic illegal_opcode_flag;
    logic interrupt_enable_flag;
    logic fetch_phase_flag;
    logic operand_phase_flag;
  } csf_ctl_t;

  // One-cycle instruction strobes from the sequencer
  typedef struct packed {
    logic compare_memory_op;
    logic compare_index_op;
    logic third_compare_op;
    logic branch_uncond_op;
    logic indirect;
    logic sense_set_op;
    logic sense_clear_op;
    logic [3:0] sense_num;    // 0..7 program flops, 8 arithmetic excess
    logic input_wait_set_op;
    logic input_wait_clear_op;
    logic interrupt_enable_op;
    logic interrupt_disable_op;
    logic interrupt_taken;
    logic arith_overflow;     // Overflow seen by add/sub/double add/sub/complement
  } csf_ins_t;

  localparam logic [3:0] CSF_SENSE_EXCESS = 4'h8;  // Sense number of the excess flag

endpackage : csf_pkg

// [hw/csf_flags.sv]
// CPU status, condition and control flag logic behind the front panel
`timescale 1ns/1ps
// What this block does
// - Twelve one-hot display selectors route a register
// - Accumulator is 24 bits wide
// - Extension register is 24 bits wide
// - Command register holds next instruction when idle
// - Buffer register holds each execute-phase memory word unless an operand first phase coincides
// - Eight 14-bit index registers, selected one displayed
// - Six console switches, up reads one, testable
// - Eight program sense flops set, clear, tested
// - Nine peripheral status lamps presented
// - Disc busy spans each disc operation
// - Input pending set/cleared, never branch-testable
// - Compares update greater, same, less; bit-match except on index compare
// - Indirect unconditional branch updates five flags
// - Overflow sets on excess or sense-set only
// - Sign lamp follows accumulator sign
// - Illegal opcode 41..77 octal sets error flag
// - Interrupt enable set/clear/interrupt/reset behaviour
// - Fetch flag during fetch, counter addresses memory
// - First phase loads command, increments counter
// - Operand flag during fetch, buffer loads first phase
// - Operand flag clears after one or two operands
// - Reset clears control flops, counter to 00100
// - Program counter is 14 bits wide
module csf_flags
  import csf_pkg::*;
(
  input wire logic ref_clk,                         // Memory-cycle clock
  input wire logic nrst,                            // Panel reset, active low
  input wire logic [CSF_NUM_SEL-1:0] sel_press,     // Display selector buttons
  input wire logic [CSF_NUM_CSW-1:0] console_sw,    // Console sense switches (pins)
  input wire logic [CSF_WORD_W-1:0] acc_in,         // Accumulator load data
  input wire logic acc_load,                        // Accumulator load strobe
  input wire logic [CSF_WORD_W-1:0] ext_in,         // Extension load data
  input wire logic ext_load,                        // Extension load strobe
  input wire logic [CSF_WORD_W-1:0] mem_rdata,      // Core memory read word
  input wire logic [CSF_WORD_W-1:0] buf_in,         // Execute-phase write word
  input wire logic buf_load,                        // Execute-phase buffer strobe
  input wire logic [CSF_WORD_W-1:0] switch_reg,     // Panel switch register
  input wire logic cmd_from_sw,                     // Load command from switches
  input wire logic pc_from_sw,                      // Load counter from switches
  input wire logic [CSF_ADDR_W-1:0] branch_addr,    // Branch target
  input wire logic branch_take,                     // Take branch strobe
  input wire logic [2:0] idx_wr_sel,                // Index register to write
  input wire logic [CSF_ADDR_W-1:0] idx_in,         // Index write data
  input wire logic idx_load,                        // Index write strobe
  input wire logic fetch_start,                     // Begin instruction fetch cycle
  input wire logic first_timing_phase,              // First timing phase of a cycle
  input wire logic operand_start,                   // Begin operand fetch cycle
  input wire logic two_operands,                    // Instruction needs two operands
  input wire csf_ins_t ins,                         // Instruction strobes
  input wire csf_cmp_t cmp,                         // Compare result
  input wire logic [3:0] mem_status,                // Memory parity/busy (pins)
  input wire logic disc_start,                      // Disc operation begins
  input wire logic disc_done,                       // Disc operation completes
  input wire logic disc_par_err,                    // Disc parity (pin)
  input wire logic [1:0] tape_status,               // Tape error, busy (pins)
  input wire logic [3:0] sense_test_num,            // Sense branch selector
  output logic sense_test_bit,                      // Sense branch test result
  output logic [CSF_WORD_W-1:0] display_lamps,      // Register display
  output logic [CSF_NUM_SEL-1:0] sel_lamps,         // Selected button lamps
  output logic [CSF_ADDR_W-1:0] pc_lamps,           // Program counter
  output logic [CSF_ADDR_W-1:0] mem_addr,           // Core memory address
  output logic [CSF_NUM_PSW-1:0] psw_lamps,         // Program sense lamps
  output logic [CSF_NUM_PER-1:0] periph_lamps,      // Peripheral status lamps
  output csf_cond_t cond_lamps,                     // Condition lamps
  output csf_ctl_t ctl_lamps                        // Control lamps
);

  // Whole state of the block; one flop bank, one next-state copy
  typedef struct packed {
    // Display selection, the registers it can show, and the program counter
    logic [CSF_NUM_SEL-1:0] sel;  // One-hot selected button
    logic [CSF_WORD_W-1:0] acc;  // Accumulator
    logic [CSF_WORD_W-1:0] ext;  // Extension
    logic [CSF_WORD_W-1:0] cmd;  // Command
    logic [CSF_WORD_W-1:0] bufr;  // Buffer
    logic [CSF_NUM_IDX-1:0][CSF_ADDR_W-1:0] idx;  // Index bank
    logic [CSF_ADDR_W-1:0] pc;  // Program counter
    // Flags and phase bookkeeping
    logic [CSF_NUM_PSW-1:0] psw;  // Program sense flops
    logic disc_busy;  // Disc operation in progress
    logic awaiting_read_flag;  // Input pending lamp
    logic [1:0] opnd_cnt;     // Operand cycles still to go
    csf_cond_t cond;  // Condition flags
    csf_ctl_t ctl;  // Control flags
    // Two-flop synchronisers for panel and peripheral pins
    logic [CSF_NUM_CSW-1:0] csw_meta;
    logic [CSF_NUM_CSW-1:0] csw_sync;
    logic [7:0] per_meta;
    logic [7:0] per_sync;
    logic [CSF_NUM_SEL-1:0] btn_meta;  // Buttons are pins too
    logic [CSF_NUM_SEL-1:0] btn_sync;
    // Display word, registered so the lamps never glitch
    logic [CSF_WORD_W-1:0] disp;
  } csf_state_t;

  csf_state_t st_reg;   // Registered state
  csf_state_t st_next;  // Next state

  // Op code in the illegal range
  // Shared by the memory and the switch load paths
  function automatic logic csf_illegal(input logic [CSF_WORD_W-1:0] word);
    logic [CSF_OP_W-1:0] op;
    op = word[CSF_OP_LSB +: CSF_OP_W];
    return (op >= CSF_OP_ILL_LO) && (op <= CSF_OP_ILL_HI);
  endfunction : csf_illegal

  // Pick the register for the display; index values zero-extended
  // Selection is one-hot, so the order of the tests below is moot
  function automatic logic [CSF_WORD_W-1:0] csf_pick(input csf_state_t s);
    logic [CSF_WORD_W-1:0] v;
    v = '0;
    for (int i = 0; i < CSF_NUM_IDX; i++)
    begin
      if (s.sel[CSF_SEL_IDX0 + i])
        v = {{(CSF_WORD_W-CSF_ADDR_W){1'b0}}, s.idx[i]};
    end
    if (s.sel[CSF_SEL_ACC]) v = s.acc;
    if (s.sel[CSF_SEL_EXT]) v = s.ext;
    if (s.sel[CSF_SEL_CMD]) v = s.cmd;
    if (s.sel[CSF_SEL_BUF]) v = s.bufr;
    return v;
  endfunction : csf_pick

  // Helpers written only by the next-state process
  logic [CSF_WORD_W-1:0] cmd_src;   // Word that loads the command register
  logic cmd_ld;                     // Command load this cycle
  logic [CSF_NUM_SEL-1:0] low_press;  // Lowest pressed selector

  // Next-state computation
  always_comb
  begin
    // Default: every register holds
    st_next = st_reg;
    // Button pins pass two flops before the selector sees them
    st_next.btn_meta = sel_press;
    st_next.btn_sync = st_reg.btn_meta;
    // Isolate the lowest set bit so the selection stays one-hot
    low_press = st_reg.btn_sync & (~st_reg.btn_sync + 12'h001);
    // New press cancels the previous one; lowest button wins ties
    if (|st_reg.btn_sync)
      st_next.sel = low_press;
    // Switch and status pins pass two flops before use
    st_next.csw_meta = console_sw;
    st_next.csw_sync = st_reg.csw_meta;
    // Bit 4 is a spare, so the tape pair sits at the top
    st_next.per_meta = {tape_status, disc_par_err, 1'b0, mem_status};
    st_next.per_sync = st_reg.per_meta;
    // Register loads from the arithmetic unit and sequencer
    if (acc_load) st_next.acc = acc_in;
    if (ext_load) st_next.ext = ext_in;
    if (idx_load) st_next.idx[idx_wr_sel] = idx_in;
    // Command loads in the fetch first phase or from switches; otherwise held while idle
    cmd_ld = (st_reg.ctl.fetch_phase_flag && first_timing_phase) || cmd_from_sw;
    cmd_src = cmd_from_sw ? switch_reg : mem_rdata;
    if (cmd_ld)
      st_next.cmd = cmd_src;
    if (cmd_ld && csf_illegal(cmd_src))
      st_next.ctl.illegal_opcode_flag = 1'b1;
    // Buffer: operand word in first phase, else execute-phase transfers
    if (st_reg.ctl.operand_phase_flag && first_timing_phase)
      st_next.bufr = mem_rdata;
    else if (buf_load)
      st_next.bufr = buf_in;
    // Program counter: branch beats increment
    // Operator switch load beats both, as the panel expects
    if (pc_from_sw)
      st_next.pc = switch_reg[CSF_ADDR_W-1:0];
    else if (branch_take)
      st_next.pc = branch_addr;
    else if (st_reg.ctl.fetch_phase_flag && first_timing_phase)
      st_next.pc = st_reg.pc + 14'h0001;
    // Fetch phase: start sets, end of first phase clears
    if (fetch_start)
      st_next.ctl.fetch_phase_flag = 1'b1;
    else if (st_reg.ctl.fetch_phase_flag && first_timing_phase)
      st_next.ctl.fetch_phase_flag = 1'b0;
    // Operand phase: ends after one or two first phases
    // Counter holds the number of operand cycles still owed
    if (operand_start)
    begin
      st_next.ctl.operand_phase_flag = 1'b1;
      st_next.opnd_cnt = two_operands ? 2'd2 : 2'd1;
    end
    else if (st_reg.ctl.operand_phase_flag && first_timing_phase)
    begin
      st_next.opnd_cnt = st_reg.opnd_cnt - 2'd1;
      if (st_reg.opnd_cnt <= 2'd1)
        st_next.ctl.operand_phase_flag = 1'b0;
    end
    // Interrupt enable: clears take priority over the set
    // A taken interrupt must never leave interrupts enabled
    if (ins.interrupt_disable_op || ins.interrupt_taken)
      st_next.ctl.interrupt_enable_flag = 1'b0;
    else if (ins.interrupt_enable_op)
      st_next.ctl.interrupt_enable_flag = 1'b1;
    // Program sense flops and the excess flag share sense numbers
    // Clear is applied first, so a set in the same cycle wins
    for (int i = 0; i < CSF_NUM_PSW; i++)
    begin
      if (ins.sense_clear_op && ins.sense_num == 4'(i))
        st_next.psw[i] = 1'b0;
      if (ins.sense_set_op && ins.sense_num == 4'(i))
        st_next.psw[i] = 1'b1;
    end
    if (ins.sense_clear_op && ins.sense_num == CSF_SENSE_EXCESS)
      st_next.cond.arith_excess_flag = 1'b0;
    // Set wins over clear on the same cycle
    if (ins.arith_overflow || (ins.sense_set_op && ins.sense_num == CSF_SENSE_EXCESS))
      st_next.cond.arith_excess_flag = 1'b1;
    // Compares
    if (ins.compare_memory_op || ins.third_compare_op ||
        (ins.branch_uncond_op && ins.indirect))
    begin
      st_next.cond.greater_flag = cmp.greater;
      st_next.cond.same_value_flag = cmp.same;
      st_next.cond.less_flag = cmp.less;
      st_next.cond.bit_match_flag = cmp.bit_match;
    end
    else if (ins.compare_index_op)
    begin
      // Bit match left as it was: not meaningful here
      st_next.cond.greater_flag = cmp.greater;
      st_next.cond.same_value_flag = cmp.same;
      st_next.cond.less_flag = cmp.less;
    end
    // Indirect branch also loads overflow from the arithmetic overflow strobe
    // The one path besides sense-clear that can drop the flag
    if (ins.branch_uncond_op && ins.indirect)
      st_next.cond.arith_excess_flag = ins.arith_overflow;
    // Sign tracks the value the accumulator holds after this edge
    st_next.cond.sign_flag = st_next.acc[CSF_SIGN_BIT];
    // Disc busy; a start in the completion cycle keeps it set
    if (disc_done)
      st_next.disc_busy = 1'b0;
    if (disc_start)
      st_next.disc_busy = 1'b1;
    // Input pending: lamp only
    if (ins.input_wait_clear_op)
      st_next.awaiting_read_flag = 1'b0;
    if (ins.input_wait_set_op)
      st_next.awaiting_read_flag = 1'b1;
    // Display lags the selection by one cycle; flop-driven lamps
    st_next.disp = csf_pick(st_reg);
  end

  // State register; panel reset clears flags and presets the counter
  // Synchronous reset, constants only, so the panel restarts clean
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      st_reg <= '0;
      st_reg.sel <= CSF_SEL_RESET;
      st_reg.pc <= CSF_PC_RESET;
    end
    else
      st_reg <= st_next;
  end

  // Sense branch test: console switches 0..5, program flops 6..13
  // Input pending has no number here, so no branch can test it
  always_comb
  begin
    sense_test_bit = 1'b0;
    if (sense_test_num < 4'(CSF_NUM_CSW))
      sense_test_bit = st_reg.csw_sync[sense_test_num[2:0]];
    else if (sense_test_num < 4'(CSF_NUM_CSW + CSF_NUM_PSW))
      sense_test_bit = st_reg.psw[3'(sense_test_num - 4'(CSF_NUM_CSW))];
    // Numbers 14 and 15 read as zero
  end

  // Lamps all from flops
  // Memory address is the counter itself, so a fetch always uses it
  assign display_lamps = st_reg.disp;
  assign sel_lamps = st_reg.sel;
  assign pc_lamps = st_reg.pc;
  assign mem_addr = st_reg.pc;
  assign psw_lamps = st_reg.psw;
  // Peripheral lamps in fixed order
  always_comb
  begin
    periph_lamps = '0;
    periph_lamps[CSF_PER_MEM_A_PAR] = st_reg.per_sync[0];
    periph_lamps[CSF_PER_MEM_B_PAR] = st_reg.per_sync[1];
    periph_lamps[CSF_PER_MEM_A_BSY] = st_reg.per_sync[2];
    periph_lamps[CSF_PER_MEM_B_BSY] = st_reg.per_sync[3];
    periph_lamps[CSF_PER_DISC_PAR] = st_reg.per_sync[5];
    periph_lamps[CSF_PER_DISC_BSY] = st_reg.disc_busy;
    // Tape pins arrive as busy over error
    periph_lamps[CSF_PER_TAPE_PAR] = st_reg.per_sync[6];
    periph_lamps[CSF_PER_TAPE_BSY] = st_reg.per_sync[7];
    periph_lamps[CSF_PER_AWAIT] = st_reg.awaiting_read_flag;
  end
  // Flag groups go out exactly as stored
  assign cond_lamps = st_reg.cond;
  assign ctl_lamps = st_reg.ctl;

endmodule : csf_flags

// [tb/csf_flags_monitor.sv]
// Concurrent checks on the flag block ports
`timescale 1ns/1ps
module csf_flags_monitor
  import csf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [CSF_NUM_SEL-1:0] sel_lamps,
  input wire logic [CSF_ADDR_W-1:0] pc_lamps,
  input wire logic [CSF_ADDR_W-1:0] mem_addr,
  input wire logic [CSF_WORD_W-1:0] display_lamps,
  input wire logic [CSF_NUM_PER-1:0] periph_lamps,
  input wire csf_ctl_t ctl_lamps,
  input wire csf_cond_t cond_lamps,
  input wire logic fetch_start,
  input wire logic first_timing_phase,
  input wire logic branch_take,
  input wire logic pc_from_sw,
  input wire logic cmd_from_sw,
  input wire logic [CSF_WORD_W-1:0] switch_reg,
  input wire logic acc_load,
  input wire logic [CSF_WORD_W-1:0] acc_in,
  input wire logic operand_start,
  input wire logic disc_start,
  input wire csf_ins_t ins
);
  // One clock domain, so one default for all checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_sel_one_hot: assert property ($onehot(sel_lamps))
    else $error("selector lamps not one-hot");
  a_reset_state: assert property ($rose(nrst) |-> pc_lamps == CSF_PC_RESET && ctl_lamps == '0)
    else $error("bad state after reset");
  a_fetch_sets: assert property (fetch_start |=> ctl_lamps.fetch_phase_flag)
    else $error("fetch flag not set");
  a_fetch_addr: assert property (ctl_lamps.fetch_phase_flag |-> mem_addr == pc_lamps)
    else $error("fetch address differs from counter");
  a_fetch_step: assert property (ctl_lamps.fetch_phase_flag && first_timing_phase && !fetch_start
    && !branch_take && !pc_from_sw |=> pc_lamps == $past(pc_lamps) + 14'h1
    && !ctl_lamps.fetch_phase_flag)
    else $error("fetch phase end wrong");
  a_illegal_op: assert property (cmd_from_sw && switch_reg[23:18] >= CSF_OP_ILL_LO
    |=> ctl_lamps.illegal_opcode_flag)
    else $error("illegal code not flagged");
  a_sign_follow: assert property (acc_load |=> cond_lamps.sign_flag == $past(acc_in[23]))
    else $error("sign lamp wrong");
  a_ien_clear: assert property (ins.interrupt_disable_op || ins.interrupt_taken
    |=> !ctl_lamps.interrupt_enable_flag)
    else $error("interrupt enable not cleared");
  a_excess_hold: assert property ($past(nrst) && $fell(cond_lamps.arith_excess_flag)
    |-> $past(ins.sense_clear_op && ins.sense_num == CSF_SENSE_EXCESS)
    || $past(ins.branch_uncond_op && ins.indirect))
    else $error("excess flag cleared without cause");
  a_operand_set: assert property (operand_start |=> ctl_lamps.operand_phase_flag)
    else $error("operand flag not set");
  a_idx_zero_ext: assert property (sel_lamps[11:4] != '0 ##1 $stable(sel_lamps)
    |-> display_lamps[23:14] == '0)
    else $error("index display upper bits lit");
  a_disc_busy: assert property (disc_start |=> periph_lamps[CSF_PER_DISC_BSY])
    else $error("disc busy not set");
endmodule : csf_flags_monitor

// [tb/csf_panel_model.sv]
// Operator panel model: selector buttons and console switches
`timescale 1ns/1ps
module csf_panel_model
  import csf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic press,
  input wire logic [3:0] btn,
  input wire logic [CSF_NUM_CSW-1:0] sw_pos,
  output logic [CSF_NUM_SEL-1:0] sel_press,
  output logic [CSF_NUM_CSW-1:0] console_sw
);
  logic [1:0] hold_cnt; // Finger stays down three cycles, then lifts
  initial sel_press = '0;
  initial hold_cnt = '0;
  initial console_sw = '0;
  // Button is held briefly, never left down
  always @(posedge ref_clk)
  begin
    console_sw <= sw_pos;
    if (press)
    begin
      sel_press <= 12'h001 << btn;
      hold_cnt <= 2'h2;
    end
    else if (hold_cnt != 2'h0)
      hold_cnt <= hold_cnt - 2'h1;
    else
      sel_press <= '0;
  end
endmodule : csf_panel_model

// [tb/test_cpu_status_control_flags.sv]
// Self-checking bench for the flag block
`timescale 1ns/1ps
module test_cpu_status_control_flags;
  import csf_pkg::*;
  logic ref_clk = 0, nrst = 0, press = 0, two_operands = 0;
  logic acc_load = 0, ext_load = 0, buf_load = 0, cmd_from_sw = 0, pc_from_sw = 0;
  logic branch_take = 0, idx_load = 0, fetch_start = 0, first_timing_phase = 0;
  logic operand_start = 0, disc_start = 0, disc_done = 0, disc_par_err = 0, sense_test_bit;
  logic [3:0] btn = '0, mem_status = '0, sense_test_num = '0;
  logic [5:0] sw_pos = '0;
  logic [1:0] tape_status = '0;
  logic [2:0] idx_wr_sel = '0;
  logic [13:0] branch_addr = '0, idx_in = '0, pc_lamps, mem_addr;
  logic [23:0] acc_in = '0, ext_in = '0, mem_rdata = '0, buf_in = '0, switch_reg = '0;
  logic [23:0] display_lamps;
  logic [11:0] sel_press, sel_lamps;
  logic [5:0] console_sw;
  logic [7:0] psw_lamps;
  logic [8:0] periph_lamps;
  csf_ins_t ins = '0;
  csf_cmp_t cmp = '0;
  csf_cond_t cond_lamps;
  csf_ctl_t ctl_lamps;
  int err_total = 0, n_checks = 0;
  csf_panel_model u_csf_panel_model (.ref_clk, .press, .btn, .sw_pos, .sel_press, .console_sw);
  csf_flags u_csf_flags (.ref_clk, .nrst, .sel_press, .console_sw, .acc_in, .acc_load, .ext_in,
    .ext_load, .mem_rdata, .buf_in, .buf_load, .switch_reg, .cmd_from_sw, .pc_from_sw,
    .branch_addr, .branch_take, .idx_wr_sel, .idx_in, .idx_load, .fetch_start,
    .first_timing_phase, .operand_start, .two_operands, .ins, .cmp, .mem_status, .disc_start,
    .disc_done, .disc_par_err, .tape_status, .sense_test_num, .sense_test_bit, .display_lamps,
    .sel_lamps, .pc_lamps, .mem_addr, .psw_lamps, .periph_lamps, .cond_lamps, .ctl_lamps);
  // 100 MHz clock
  initial forever #5 ref_clk = ~ref_clk;
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Press a selector and let the display settle
  task automatic show(input logic [3:0] b);
    press = 1;
    btn = b;
    tick(1);
    press = 0;
    tick(5);
  endtask : show
  task automatic reset_run();
    nrst = 0;
    tick(16);
    nrst = 1;
  endtask : reset_run
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // Hang guard, well beyond the sequence length
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    conclude();
  end
  initial
  begin
    tick(1);
    reset_run();
    chk(24'(pc_lamps), 24'h40); chk(24'(sel_lamps), 24'h1); chk(24'(ctl_lamps), 24'h0);
    cmd_from_sw = 1; switch_reg = 24'h800000; tick(1); cmd_from_sw = 0; tick(1);
    chk(24'(ctl_lamps), 24'h0);
    cmd_from_sw = 1; switch_reg = 24'hfc0000; tick(1); cmd_from_sw = 0; tick(1);
    chk(24'(ctl_lamps), 24'h8);
    reset_run();
    fetch_start = 1; tick(1); fetch_start = 0;
    chk(24'(ctl_lamps), 24'h2); chk(24'(mem_addr), 24'h40);
    first_timing_phase = 1; mem_rdata = 24'h840123; tick(1); first_timing_phase = 0;
    chk(24'(pc_lamps), 24'h41); chk(24'(ctl_lamps), 24'h8);
    show(4'h2); chk(display_lamps, 24'h840123);
    operand_start = 1; tick(1); operand_start = 0; chk(24'(ctl_lamps), 24'h9);
    first_timing_phase = 1; mem_rdata = 24'h5a5a5a; tick(1); first_timing_phase = 0;
    chk(24'(ctl_lamps), 24'h8); show(4'h3); chk(display_lamps, 24'h5a5a5a);
    two_operands = 1; operand_start = 1; tick(1); operand_start = 0; two_operands = 0;
    first_timing_phase = 1; tick(1); first_timing_phase = 0; tick(1);
    chk(24'(ctl_lamps), 24'h9);
    first_timing_phase = 1; tick(1); first_timing_phase = 0;
    chk(24'(ctl_lamps), 24'h8);
    acc_load = 1; acc_in = 24'h800001; tick(1); acc_load = 0; tick(1);
    chk(24'(cond_lamps), 24'h1); show(4'h0); chk(display_lamps, 24'h800001);
    ext_load = 1; ext_in = 24'h123456; tick(1); ext_load = 0; show(4'h1);
    chk(display_lamps, 24'h123456);
    idx_load = 1; idx_wr_sel = 3'h5; idx_in = 14'h2abc; tick(1); idx_load = 0; show(4'h9);
    chk(display_lamps, 24'h002abc);
    sw_pos = 6'h2a; tick(4);
    for (int i = 0; i < 6; i++)
    begin
      sense_test_num = 4'(i); tick(1);
      chk(24'(sense_test_bit), 24'((6'h2a >> i) & 6'h1));
    end
    ins.sense_set_op = 1;
    for (int i = 0; i < 9; i++)
    begin
      ins.sense_num = 4'(i); tick(1);
    end
    ins.sense_set_op = 0; tick(1);
    chk(24'(psw_lamps), 24'hff); chk(24'(cond_lamps.arith_excess_flag), 24'h1);
    ins.sense_clear_op = 1;
    for (int i = 0; i < 9; i += 2)
    begin
      ins.sense_num = 4'(i); tick(1);
    end
    ins.sense_clear_op = 0; tick(1);
    chk(24'(psw_lamps), 24'haa); chk(24'(cond_lamps.arith_excess_flag), 24'h0);
    for (int i = 0; i < 8; i++)
    begin
      sense_test_num = 4'(6 + i); tick(1);
      chk(24'(sense_test_bit), 24'((8'haa >> i) & 8'h1));
    end
    ins.arith_overflow = 1; tick(1); ins.arith_overflow = 0; tick(2);
    chk(24'(cond_lamps.arith_excess_flag), 24'h1);
    cmp = csf_cmp_t'(4'h9); ins.compare_memory_op = 1; tick(1); ins.compare_memory_op = 0;
    tick(1); chk(24'(cond_lamps), 24'h27);
    cmp = csf_cmp_t'(4'h2); ins.compare_index_op = 1; tick(1); ins.compare_index_op = 0;
    tick(1); chk(24'(cond_lamps[5:3]), 24'h1);
    cmp = csf_cmp_t'(4'h4); ins.branch_uncond_op = 1; ins.indirect = 1; tick(1);
    ins.branch_uncond_op = 0; ins.indirect = 0; tick(1);
    chk(24'(cond_lamps), 24'h11);
    ins.interrupt_enable_op = 1; tick(1); ins.interrupt_enable_op = 0; tick(1);
    chk(24'(ctl_lamps), 24'hc);
    ins.interrupt_taken = 1; tick(1); ins.interrupt_taken = 0; tick(1);
    chk(24'(ctl_lamps), 24'h8);
    mem_status = 4'ha; tape_status = 2'h2; disc_par_err = 1; disc_start = 1;
    ins.input_wait_set_op = 1; tick(1); disc_start = 0; ins.input_wait_set_op = 0; tick(3);
    chk(24'(periph_lamps), 24'h1ba);
    disc_done = 1; ins.input_wait_clear_op = 1; tick(1);
    disc_done = 0; ins.input_wait_clear_op = 0; tick(1);
    chk(24'(periph_lamps), 24'h09a);
    conclude();
  end
endmodule : test_cpu_status_control_flags
bind csf_flags csf_flags_monitor u_csf_flags_monitor (.ref_clk, .nrst, .sel_lamps, .pc_lamps,
  .mem_addr, .display_lamps, .periph_lamps, .ctl_lamps, .cond_lamps, .fetch_start,
  .first_timing_phase, .branch_take, .pc_from_sw, .cmd_from_sw, .switch_reg, .acc_load,
  .acc_in, .operand_start, .disc_start, .ins);
